/* logic/rcc_rail_c_regs.sv */
// rail c configuration registers, current/thermal/power telemetry and fixed-group checksum
// Behaviour
// - range field picks the lift current table
// - code zero disables lift; low range 0.125-1.25uA
// - width code gives 0.4/0.55/0.75/0.92 on-time
// - feature bit 7 enables flat load-line
// - feature bit 5 enables soft-start overcurrent
// - feature bit 4 picks gain 2/3 or 1
// - per-rail signed eight-bit current offset
// - reported current is adc minus offset
// - sixteen-bit configuration identifier, two bytes
// - crc-8 over fixed group at power-on/restore
// - over-temperature flag when thermistor voltage below threshold, or stage voltage above it
// - temperature updated each 700us, 5.6ms average
// - setting picks thermistor or power-stage input
// - stage mode: 0.6V at 0C, 8mV/C
// - system power is ten-bit code, eight scales
// - system power full scale 1.6V or 3.2V
// - power input tied high disables power monitor
// - flat load-line: target dips on step, recovers
// - current full scale comes from nonvolatile config
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_rail_c_regs #(
   parameter int          TEMP_UPD_CYC = `RCC_TEMP_UPD_CYC,
   parameter int          AVG_DEPTH    = `RCC_TEMP_AVG_DEPTH,
   parameter int          FIXED_BYTES  = 16,
   parameter int          DECAY_CYC    = `RCC_FLAT_DECAY_CYC,
   parameter logic [15:0] CONFIG_IDENT = 16'h5a3c  // arbitrary value
) (
   // clock, reset, enable
   input  wire logic                     clk_sys_i,
   input  wire logic                     srst_i,
   input  wire logic                     ce_i,
   // register port
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic                     reg_wr_i,
   input  wire logic [7:0]               reg_wdata_i,
   input  wire logic                     reg_rd_i,
   output logic      [7:0]               reg_rdata_o,
   // nonvolatile settings
   input  wire logic                     nvm_restore_i,
   input  wire logic [8*FIXED_BYTES-1:0] nvm_fixed_group_i,
   input  wire logic [7:0]               nvm_iout_scale_i,
   input  wire logic                     nvm_thermal_sense_input_stage_i,
   input  wire logic                     nvm_psys_fs_hi_i,
   input  wire logic [2:0]               nvm_psys_scale_i,
   // current adc
   input  wire logic                     cur_adc_valid_i,
   input  wire logic [1:0]               cur_adc_rail_i,
   input  wire logic [9:0]               cur_adc_i,
   // thermal input
   input  wire logic [11:0]              thermal_sense_mv_i,
   input  wire logic [11:0]              hot_threshold_i,
   // system power input
   input  wire logic [11:0]              psys_mv_i,
   input  wire logic                     psys_pin_at_vcc_i,
   // load transient
   input  wire logic [9:0]               vid_target_i,
   input  wire logic                     load_step_valid_i,
   input  wire logic [9:0]               load_step_i,
   input  wire logic [7:0]               loadline_slope_i,
   // rail c controls
   output logic      [7:0]               rail_c_lift_sink_o,
   output logic      [6:0]               rail_c_qr_width_pct_o,
   output logic                          rail_c_flat_loadline_en_o,
   output logic                          rail_c_softstart_overcurrent_en_o,
   output logic                          rail_c_amp_gain_unity_o,
   output logic      [9:0]               rail_c_volt_target_o,
   // telemetry
   output logic      [9:0]               current_tlm_a_o,
   output logic      [9:0]               current_tlm_b_o,
   output logic      [9:0]               current_tlm_c_o,
   output logic      [7:0]               iout_scale_o,
   output logic      [11:0]              temp_tlm_o,
   output logic                          over_temperature_flag_o,
   output logic      [9:0]               psys_tlm_o,
   output logic      [2:0]               psys_scale_o,
   output logic                          psys_en_o
);
   localparam int TW = $clog2(TEMP_UPD_CYC + 1);
   localparam int AW = (AVG_DEPTH > 1) ? $clog2(AVG_DEPTH) : 1;
   localparam int SW = 12 + AW;
   localparam int IW = $clog2(FIXED_BYTES + 1);
   localparam int DW = $clog2(DECAY_CYC + 1);

   // lift current in 1/32 uA: base table scaled by range
   function automatic logic [7:0] lift_current(input logic [1:0] range, input logic [2:0] code);
      logic [7:0] base;
      base = 8'h00;
      case (code)
         3'h1: base = 8'h04;
         3'h2: base = 8'h08;
         3'h3: base = 8'h0c;
         3'h4: base = 8'h10;
         3'h5: base = 8'h14;
         3'h6: base = 8'h1c;
         3'h7: base = 8'h28;
         default: base = 8'h00;  // zero code disables lift
      endcase
      case (range)
         2'h0: return base;
         2'h1: return 8'(base << 1);
         2'h2: return 8'((base * 5) >> 1);
         default: return 8'(base * 5);
      endcase
   endfunction

   // adc minus signed offset, saturated
   function automatic logic [9:0] tlm_sub(input logic [9:0] adc, input logic [7:0] off);
      logic signed [11:0] d;
      d = $signed({2'b00, adc}) - $signed({{4{off[7]}}, off});
      if (d < 0) begin
         return 10'h000;
      end else if (d > $signed({2'b00, `RCC_TLM_FULL})) begin
         return `RCC_TLM_FULL;
      end else begin
         return d[9:0];
      end
   endfunction

   logic [7:0] lift_q;
   logic [7:0] qrw_q;
   logic [7:0] feat_q;
   logic [7:0] off_a_q;
   logic [7:0] off_b_q;
   logic [7:0] off_c_q;
   logic [7:0] csum_q;
   logic [7:0] rdata_d;

   // software writes to the writable registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         lift_q  <= `RCC_RST_LIFT;
         qrw_q   <= `RCC_RST_QRW;
         feat_q  <= `RCC_RST_FEAT;
         off_a_q <= `RCC_RST_OFF;
         off_b_q <= `RCC_RST_OFF;
         off_c_q <= `RCC_RST_OFF;
      end else if (ce_i && reg_wr_i) begin
         case (reg_addr_i)
            `RCC_ADDR_LIFT:  lift_q  <= reg_wdata_i;
            `RCC_ADDR_QRW:   qrw_q   <= reg_wdata_i;  // upper bits stored as given
            `RCC_ADDR_FEAT:  feat_q  <= reg_wdata_i;
            `RCC_ADDR_OFF_A: off_a_q <= reg_wdata_i;
            `RCC_ADDR_OFF_B: off_b_q <= reg_wdata_i;
            `RCC_ADDR_OFF_C: off_c_q <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // read mux
   always_comb begin
      case (reg_addr_i)
         `RCC_ADDR_LIFT:     rdata_d = lift_q;
         `RCC_ADDR_QRW:      rdata_d = qrw_q;
         `RCC_ADDR_FEAT:     rdata_d = feat_q;
         `RCC_ADDR_OFF_A:    rdata_d = off_a_q;
         `RCC_ADDR_OFF_B:    rdata_d = off_b_q;
         `RCC_ADDR_OFF_C:    rdata_d = off_c_q;
         `RCC_ADDR_IDENT_LO: rdata_d = CONFIG_IDENT[7:0];
         `RCC_ADDR_IDENT_HI: rdata_d = CONFIG_IDENT[15:8];
         `RCC_ADDR_CSUM:     rdata_d = csum_q;
         default:            rdata_d = 8'h00;
      endcase
   end

   // registered read data
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   // rail c decoded controls
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rail_c_lift_sink_o                <= 8'h00;
         rail_c_qr_width_pct_o             <= `RCC_QRW_PCT0;
         rail_c_flat_loadline_en_o         <= 1'b0;
         rail_c_softstart_overcurrent_en_o <= 1'b0;
         rail_c_amp_gain_unity_o           <= 1'b0;
      end else if (ce_i) begin
         rail_c_lift_sink_o <= lift_current(lift_q[`RCC_LIFT_RANGE_LSB +: 2], lift_q[2:0]);
         case (qrw_q[1:0])
            2'h0:    rail_c_qr_width_pct_o <= `RCC_QRW_PCT0;
            2'h1:    rail_c_qr_width_pct_o <= `RCC_QRW_PCT1;
            2'h2:    rail_c_qr_width_pct_o <= `RCC_QRW_PCT2;
            default: rail_c_qr_width_pct_o <= `RCC_QRW_PCT3;
         endcase
         rail_c_flat_loadline_en_o         <= feat_q[`RCC_FEAT_FLAT_BIT];
         rail_c_softstart_overcurrent_en_o <= feat_q[`RCC_FEAT_SSOC_BIT];
         rail_c_amp_gain_unity_o           <= feat_q[`RCC_FEAT_GAIN_BIT];
      end
   end

   // current telemetry per rail
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         current_tlm_a_o <= 10'h000;
         current_tlm_b_o <= 10'h000;
         current_tlm_c_o <= 10'h000;
      end else if (ce_i && cur_adc_valid_i) begin
         case (cur_adc_rail_i)
            2'h0:    current_tlm_a_o <= tlm_sub(cur_adc_i, off_a_q);
            2'h1:    current_tlm_b_o <= tlm_sub(cur_adc_i, off_b_q);
            2'h2:    current_tlm_c_o <= tlm_sub(cur_adc_i, off_c_q);
            default: ;
         endcase
      end
   end

   // fixed-group checksum sequencer
   rcc_pkg::rcc_crc_state_type crc_st_q;
   logic          por_pend_q;
   logic [IW-1:0] crc_idx_q;
   logic          crc_clear;
   logic          crc_valid;
   logic [7:0]    crc_byte;
   logic [7:0]    crc_val;

   assign crc_clear = (crc_st_q == rcc_pkg::CRC_IDLE) && (por_pend_q || nvm_restore_i);
   assign crc_valid = (crc_st_q == rcc_pkg::CRC_RUN);
   assign crc_byte  = (crc_idx_q < IW'(FIXED_BYTES)) ? nvm_fixed_group_i[8*crc_idx_q +: 8]
                                                   : (feat_q & `RCC_FEAT_FIX_MASK);

   // refresh only at power-on and nonvolatile restore, never on live writes
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         crc_st_q     <= rcc_pkg::CRC_IDLE;
         por_pend_q   <= 1'b1;
         crc_idx_q    <= '0;
         csum_q       <= 8'h00;
         iout_scale_o <= 8'h00;
      end else if (ce_i) begin
         case (crc_st_q)
            rcc_pkg::CRC_IDLE: begin
               if (crc_clear) begin
                  por_pend_q   <= 1'b0;
                  crc_idx_q    <= '0;
                  iout_scale_o <= nvm_iout_scale_i;
                  crc_st_q     <= rcc_pkg::CRC_RUN;
               end
            end
            rcc_pkg::CRC_RUN: begin
               if (crc_idx_q == IW'(FIXED_BYTES)) begin
                  crc_st_q <= rcc_pkg::CRC_LATCH;
               end else begin
                  crc_idx_q <= crc_idx_q + 1'b1;
               end
            end
            rcc_pkg::CRC_LATCH: begin
               csum_q   <= crc_val;
               crc_st_q <= rcc_pkg::CRC_IDLE;
            end
            default: crc_st_q <= rcc_pkg::CRC_IDLE;
         endcase
      end
   end

   rcc_crc8 u_crc (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .clear_i   (crc_clear),
      .valid_i   (crc_valid),
      .byte_i    (crc_byte),
      .crc_o     (crc_val)
   );

   // thermal sampling and running average
   rcc_pkg::rcc_therm_state_type th_st_q;
   logic [TW-1:0] tcnt_q;
   logic          t_tick;
   logic [11:0]   samp_q;
   logic [AW-1:0] ptr_q;
   logic [AW:0]   fill_q;
   logic [SW-1:0] sum_q;
   logic [11:0]   old_samp;
   logic [11:0]   ram_rdata;
   logic [11:0]   avg_mv;
   logic [11:0]   stage_deg;

   assign t_tick    = (tcnt_q == TW'(TEMP_UPD_CYC - 1));
   assign old_samp  = (fill_q == (AW + 1)'(AVG_DEPTH)) ? ram_rdata : 12'h000;
   assign avg_mv    = 12'(sum_q / SW'(AVG_DEPTH));
   assign stage_deg = (avg_mv < 12'(`RCC_STAGE_ZERO_MV)) ? 12'h000
                    : 12'((avg_mv - 12'(`RCC_STAGE_ZERO_MV)) / 12'(`RCC_STAGE_MV_DEG));

   // update interval counter
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         tcnt_q <= '0;
      end else if (ce_i) begin
         tcnt_q <= t_tick ? '0 : tcnt_q + 1'b1;
      end
   end

   // sample, accumulate, publish
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         th_st_q                 <= rcc_pkg::TH_IDLE;
         samp_q                  <= 12'h000;
         ptr_q                   <= '0;
         fill_q                  <= '0;
         sum_q                   <= '0;
         temp_tlm_o              <= 12'h000;
         over_temperature_flag_o <= 1'b0;
      end else if (ce_i) begin
         case (th_st_q)
            rcc_pkg::TH_IDLE: begin
               if (t_tick) begin
                  samp_q  <= thermal_sense_mv_i;
                  th_st_q <= rcc_pkg::TH_ACC;
               end
            end
            rcc_pkg::TH_ACC: begin
               sum_q   <= sum_q + SW'(samp_q) - SW'(old_samp);
               ptr_q   <= (ptr_q == AW'(AVG_DEPTH - 1)) ? '0 : ptr_q + 1'b1;
               if (fill_q != (AW + 1)'(AVG_DEPTH)) begin
                  fill_q <= fill_q + 1'b1;
               end
               th_st_q <= rcc_pkg::TH_UPD;
            end
            rcc_pkg::TH_UPD: begin
               if (nvm_thermal_sense_input_stage_i) begin
                  temp_tlm_o              <= stage_deg;
                  over_temperature_flag_o <= (avg_mv > hot_threshold_i);
               end else begin
                  temp_tlm_o              <= avg_mv;
                  over_temperature_flag_o <= (avg_mv < hot_threshold_i);
               end
               th_st_q <= rcc_pkg::TH_IDLE;
            end
            default: th_st_q <= rcc_pkg::TH_IDLE;
         endcase
      end
   end

   rcc_sample_ram #(
      .W     (12),
      .DEPTH (AVG_DEPTH),
      .AW    (AW)
   ) u_ram (
      .clk_sys_i (clk_sys_i),
      .ce_i      (ce_i),
      .we_i      (th_st_q == rcc_pkg::TH_ACC),
      .waddr_i   (ptr_q),
      .wdata_i   (samp_q),
      .re_i      (t_tick && (th_st_q == rcc_pkg::TH_IDLE)),
      .raddr_i   (ptr_q),
      .rdata_o   (ram_rdata)
   );

   // system input power telemetry
   logic [21:0] psys_prod;
   logic [21:0] psys_code;

   assign psys_prod = 22'(psys_mv_i * 22'(`RCC_TLM_DIV));
   assign psys_code = nvm_psys_fs_hi_i ? psys_prod / 22'(`RCC_PSYS_FS_HI_MV)
                                       : psys_prod / 22'(`RCC_PSYS_FS_LO_MV);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         psys_tlm_o   <= 10'h000;
         psys_scale_o <= 3'h0;
         psys_en_o    <= 1'b0;
      end else if (ce_i) begin
         psys_en_o    <= !psys_pin_at_vcc_i;
         psys_scale_o <= nvm_psys_scale_i;
         if (psys_pin_at_vcc_i) begin
            psys_tlm_o <= 10'h000;
         end else if (psys_code > 22'(`RCC_TLM_FULL)) begin
            psys_tlm_o <= `RCC_TLM_FULL;
         end else begin
            psys_tlm_o <= psys_code[9:0];
         end
      end
   end

   // flat load-line transient dip and slow recovery
   logic [17:0]   step_prod;
   logic [9:0]    step_drop;
   logic [9:0]    drop_q;
   logic [DW-1:0] dcnt_q;

   assign step_prod = load_step_i * loadline_slope_i;
   assign step_drop = (step_prod[17:8] > drop_q) ? step_prod[17:8] : drop_q;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         drop_q               <= 10'h000;
         dcnt_q               <= '0;
         rail_c_volt_target_o <= 10'h000;
      end else if (ce_i) begin
         if (!feat_q[`RCC_FEAT_FLAT_BIT]) begin
            drop_q <= 10'h000;
            dcnt_q <= '0;
         end else if (load_step_valid_i) begin
            drop_q <= step_drop;
            dcnt_q <= '0;
         end else if (drop_q != 10'h000) begin
            if (dcnt_q == DW'(DECAY_CYC - 1)) begin
               dcnt_q <= '0;
               drop_q <= drop_q - 1'b1;
            end else begin
               dcnt_q <= dcnt_q + 1'b1;
            end
         end
         rail_c_volt_target_o <= (vid_target_i > drop_q) ? vid_target_i - drop_q : 10'h000;
      end
   end
endmodule // rcc_rail_c_regs

/* logic/rcc_consts.svh */
// offsets, field positions, reset values and timing counts of the rail C register bank
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

// register offsets
`define RCC_ADDR_LIFT      8'h39
`define RCC_ADDR_QRW       8'h3a
`define RCC_ADDR_FEAT      8'h3b
`define RCC_ADDR_SPARE_A   8'h3c
`define RCC_ADDR_SPARE_B   8'h3d
`define RCC_ADDR_OFF_A     8'h3e
`define RCC_ADDR_OFF_B     8'h3f
`define RCC_ADDR_OFF_C     8'h40
`define RCC_ADDR_IDENT_LO  8'h41
`define RCC_ADDR_IDENT_HI  8'h42
`define RCC_ADDR_CSUM      8'h43

// reset values
`define RCC_RST_LIFT       8'h00
`define RCC_RST_QRW        8'h20
`define RCC_RST_FEAT       8'h00
`define RCC_RST_OFF        8'h00

// field positions
`define RCC_LIFT_RANGE_LSB 4
`define RCC_FEAT_FLAT_BIT  7
`define RCC_FEAT_SSOC_BIT  5
`define RCC_FEAT_GAIN_BIT  4
`define RCC_FEAT_FIX_MASK  8'h50

// quick-response widths in hundredths of on-time
`define RCC_QRW_PCT0       7'h28
`define RCC_QRW_PCT1       7'h37
`define RCC_QRW_PCT2       7'h4b
`define RCC_QRW_PCT3       7'h5c

// telemetry scaling
`define RCC_TLM_FULL       10'h3ff
`define RCC_TLM_DIV        1023
`define RCC_STAGE_ZERO_MV  600
`define RCC_STAGE_MV_DEG   8
`define RCC_PSYS_FS_LO_MV  1600
`define RCC_PSYS_FS_HI_MV  3200

// checksum polynomial x^8+x^2+x+1
`define RCC_CRC_POLY       8'h07

// timing
`define RCC_CLK_NS         100
`define RCC_TEMP_UPD_NS    700000
`define RCC_TEMP_AVG_NS    5600000
`define RCC_TEMP_UPD_CYC   (`RCC_TEMP_UPD_NS / `RCC_CLK_NS)
`define RCC_TEMP_AVG_DEPTH (`RCC_TEMP_AVG_NS / `RCC_TEMP_UPD_NS)
`define RCC_FLAT_DECAY_CYC 64

`endif

/* logic/rcc_pkg.sv */
// types shared by the rail C register bank
package rcc_pkg;
   typedef enum logic [1:0] {CRC_IDLE, CRC_RUN, CRC_LATCH} rcc_crc_state_type;
   typedef enum logic [1:0] {TH_IDLE, TH_ACC, TH_UPD} rcc_therm_state_type;
endpackage

/* logic/rcc_sample_ram.sv */
// small sample memory with registered read data
`timescale 1ns/1ps
module rcc_sample_ram #(
   parameter int W     = 12,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   // clock and enable
   input  wire logic          clk_sys_i,
   input  wire logic          ce_i,
   // write side
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [W-1:0]  wdata_i,
   // read side
   input  wire logic          re_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [W-1:0]  rdata_o
);
   logic [W-1:0] mem_q [DEPTH];

   // storage write
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   // registered read
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && re_i) begin
         rdata_o <= mem_q[raddr_i];
      end
   end
endmodule // rcc_sample_ram

/* logic/rcc_crc8.sv */
// byte-serial crc-8 engine
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_crc8 (
   // clock, reset, enable
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   input  wire logic       ce_i,
   // byte stream
   input  wire logic       clear_i,
   input  wire logic       valid_i,
   input  wire logic [7:0] byte_i,
   // running result
   output logic      [7:0] crc_o
);
   // one byte through the polynomial, msb first
   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `RCC_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // accumulate
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         crc_o <= 8'h00;
      end else if (ce_i) begin
         if (clear_i) begin
            crc_o <= 8'h00;
         end else if (valid_i) begin
            crc_o <= crc_step(crc_o, byte_i);
         end
      end
   end
endmodule // rcc_crc8

/* verification/rcc_rail_c_regs_props.sv */
// assertions on the rail c register bank ports
`timescale 1ns/1ps
module rcc_rail_c_regs_props #(
   parameter logic [15:0] CONFIG_IDENT = 16'h5a3c  // arbitrary value
) (
   // clock and reset
   input wire logic       clk_sys_i,
   input wire logic       srst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // telemetry
   input wire logic       cur_adc_valid_i,
   input wire logic [1:0] cur_adc_rail_i,
   input wire logic [9:0] current_tlm_a_o,
   input wire logic       psys_pin_at_vcc_i,
   input wire logic       psys_en_o,
   input wire logic [9:0] psys_tlm_o,
   // rail c controls
   input wire logic [7:0] rail_c_lift_sink_o,
   input wire logic [6:0] rail_c_qr_width_pct_o,
   input wire logic       rail_c_flat_loadline_en_o,
   input wire logic       rail_c_softstart_overcurrent_en_o,
   input wire logic       rail_c_amp_gain_unity_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // width table per code
   logic [6:0] pct [4];
   assign pct = '{7'h28, 7'h37, 7'h4b, 7'h5c};
   AST_QRW: assert property (reg_wr_i && reg_addr_i == 8'h3a |-> ##2
      rail_c_qr_width_pct_o == pct[$past(reg_wdata_i[1:0], 2)]) else $error("qr width wrong");
   AST_LIFT_OFF: assert property (reg_wr_i && reg_addr_i == 8'h39 && reg_wdata_i[2:0] == 3'h0
      |-> ##2 rail_c_lift_sink_o == 8'h00) else $error("lift not off");
   AST_FLAT: assert property (reg_wr_i && reg_addr_i == 8'h3b |-> ##2
      rail_c_flat_loadline_en_o == $past(reg_wdata_i[7], 2)) else $error("flat enable wrong");
   AST_SSOC: assert property (reg_wr_i && reg_addr_i == 8'h3b |-> ##2
      rail_c_softstart_overcurrent_en_o == $past(reg_wdata_i[5], 2)) else $error("ssoc enable wrong");
   AST_GAIN: assert property (reg_wr_i && reg_addr_i == 8'h3b |-> ##2
      rail_c_amp_gain_unity_o == $past(reg_wdata_i[4], 2)) else $error("gain select wrong");
   AST_IDENT: assert property (reg_rd_i && reg_addr_i == 8'h41 |=>
      reg_rdata_o == CONFIG_IDENT[7:0]) else $error("ident low wrong");
   AST_PSYS_OFF: assert property (psys_pin_at_vcc_i |=> !psys_en_o && psys_tlm_o == 10'h000)
      else $error("psys not disabled");
   AST_TLM_HOLD: assert property (!(cur_adc_valid_i && cur_adc_rail_i == 2'h0) |=>
      $stable(current_tlm_a_o)) else $error("current telemetry moved");
endmodule // rcc_rail_c_regs_props

bind rcc_rail_c_regs rcc_rail_c_regs_props #(.CONFIG_IDENT(CONFIG_IDENT)) u_rcc_rail_c_regs_props (.*);

/* verification/rcc_host_model.sv */
// host model driving the register port
`timescale 1ns/1ps
module rcc_host_model (
   // clock
   input  wire logic       clk_sys_i,
   // register port
   output logic      [7:0] addr_o,
   output logic            wr_o,
   output logic      [7:0] wdata_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   // idle bus at time zero
   initial begin
      {addr_o, wr_o, wdata_o, rd_o} = '0;
   end
   // one write, then a quiet cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
      @(posedge clk_sys_i);
      #1;
   endtask
   // one read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~a;
      @(posedge clk_sys_i);
      #1;
      d = rdata_i;
   endtask
endmodule // rcc_host_model

/* verification/tb_rcc_rail_c_regs.sv */
// self-checking bench for the rail c register bank
`timescale 1ns/1ps
module tb_rcc_rail_c_regs;
   logic         clk_sys_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, nvm_restore_i = 1'b0, nvm_thermal_sense_input_stage_i = 1'b0;
   logic         nvm_psys_fs_hi_i = 1'b0, cur_adc_valid_i = 1'b0, psys_pin_at_vcc_i = 1'b1, load_step_valid_i = 1'b0;
   logic         reg_wr_i, reg_rd_i, rail_c_flat_loadline_en_o, rail_c_softstart_overcurrent_en_o;
   logic         rail_c_amp_gain_unity_o, over_temperature_flag_o, psys_en_o;
   logic [7:0]   reg_addr_i, reg_wdata_i, reg_rdata_o, rail_c_lift_sink_o, iout_scale_o, v, crc;
   logic [7:0]   nvm_iout_scale_i = 8'h42, loadline_slope_i = 8'h10;
   logic [127:0] nvm_fixed_group_i;
   logic [2:0]   nvm_psys_scale_i = 3'h5, psys_scale_o;
   logic [1:0]   cur_adc_rail_i = 2'h0;
   logic [9:0]   cur_adc_i = 10'h000, vid_target_i = 10'h200, load_step_i = 10'h100;
   logic [9:0]   rail_c_volt_target_o, psys_tlm_o, current_tlm_a_o, current_tlm_b_o, current_tlm_c_o;
   logic [11:0]  thermal_sense_mv_i = 12'h1f4, hot_threshold_i = 12'h258, psys_mv_i = 12'h640, temp_tlm_o;
   logic [6:0]   rail_c_qr_width_pct_o;
   wire logic [2:0] flg = {rail_c_flat_loadline_en_o, rail_c_softstart_overcurrent_en_o, rail_c_amp_gain_unity_o};
   logic [7:0]   ra [10] = '{8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h50};
   logic [7:0]   re [10] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h5a, 8'h00};
   logic [7:0]   lw [5] = '{8'h00, 8'h07, 8'h17, 8'h24, 8'h30};
   logic [11:0]  lx [5] = '{12'h000, 12'h028, 12'h050, 12'h028, 12'h000};
   logic [11:0]  qw [4] = '{12'h028, 12'h037, 12'h04b, 12'h05c};
   int           miscompares = 0, tests_run = 0;

   rcc_rail_c_regs #(.TEMP_UPD_CYC(20), .DECAY_CYC(4)) u_rcc_rail_c_regs (.*);
   rcc_host_model u_rcc_host_model (.clk_sys_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i),
      .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));

   // 10 MHz clock
   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // fixed group bytes
   initial begin
      for (int k = 0; k < 16; k++) nvm_fixed_group_i[8*k+:8] = 8'(k + 1);
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_rcc_host_model.rd(a, v);
      chk("register", 12'(v), 12'(e));
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      u_rcc_host_model.wr(a, d);
   endtask
   task automatic adc(input logic [1:0] r, input logic [9:0] d);
      cur_adc_rail_i = r;
      cur_adc_i = d;
      cur_adc_valid_i = 1'b1;
      step(1);
      cur_adc_valid_i = 1'b0;
      step(1);
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      c = c ^ b;
      for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      return c;
   endfunction
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // watchdog
   initial begin
      #(5000 * 100);
      miscompares++;
      finish_test();
   end
   // main sequence
   initial begin
      step(20);
      srst_i = 1'b0;
      step(2);
      chk("psys_en", 12'(psys_en_o), 12'h000);
      chk("iout_scale", 12'(iout_scale_o), 12'h042);
      for (int k = 0; k < 10; k++) rchk(ra[k], re[k]);
      w(8'h41, 8'hff);
      rchk(8'h41, 8'h3c);
      for (int k = 0; k < 4; k++) begin
         w(8'h3a, 8'h20 | 8'(k));
         chk("qr_width", 12'(rail_c_qr_width_pct_o), qw[k]);
      end
      for (int k = 0; k < 5; k++) begin
         w(8'h39, lw[k]);
         chk("lift_sink", 12'(rail_c_lift_sink_o), lx[k]);
      end
      w(8'h3b, 8'hb0);
      chk("flags", 12'(flg), 12'h007);
      load_step_valid_i = 1'b1;
      step(1);
      load_step_valid_i = 1'b0;
      step(1);
      chk("volt_dip", 12'(rail_c_volt_target_o inside {[10'h1f0:10'h1f1]}), 12'h001);
      crc = 8'h00;
      for (int k = 0; k < 16; k++) crc = crc8(crc, 8'(k + 1));
      crc = crc8(crc, 8'h10);
      nvm_restore_i = 1'b1;
      step(1);
      nvm_restore_i = 1'b0;
      step(24);
      rchk(8'h43, crc);
      w(8'h3b, 8'h00);
      step(2);
      chk("flags", 12'(flg), 12'h000);
      chk("volt_target", 12'(rail_c_volt_target_o), 12'h200);
      w(8'h3e, 8'hff);
      w(8'h3f, 8'h7f);
      w(8'h40, 8'h80);
      rchk(8'h40, 8'h80);
      adc(2'h0, 10'h00a);
      chk("tlm_a", 12'(current_tlm_a_o), 12'h00b);
      adc(2'h1, 10'h005);
      chk("tlm_b", 12'(current_tlm_b_o), 12'h000);
      adc(2'h2, 10'h3f0);
      chk("tlm_c", 12'(current_tlm_c_o), 12'h3ff);
      ce_i = 1'b0;
      w(8'h3e, 8'h01);
      ce_i = 1'b1;
      rchk(8'h3e, 8'hff);
      psys_pin_at_vcc_i = 1'b0;
      step(3);
      chk("psys", 12'({psys_en_o, psys_scale_o, psys_tlm_o[9:2]}), 12'hdff);
      nvm_psys_fs_hi_i = 1'b1;
      step(3);
      chk("psys_tlm", 12'(psys_tlm_o), 12'h1ff);
      step(200);
      chk("temp", temp_tlm_o, 12'h1f4);
      chk("hot_flag", 12'(over_temperature_flag_o), 12'h001);
      thermal_sense_mv_i = 12'h320;
      nvm_thermal_sense_input_stage_i = 1'b1;
      step(200);
      chk("temp_stage", temp_tlm_o, 12'h019);
      finish_test();
   end
endmodule // tb_rcc_rail_c_regs
